/* hw/vic_defines.svh */
`ifndef VIC_DEFINES_SVH
`define VIC_DEFINES_SVH

// ----------------------------------------------------------------------
// sizes
// ----------------------------------------------------------------------
`define VIC_NUM_SRC 54
`define VIC_NUM_SLOT 32
`define VIC_NUM_GPIO 19
`define VIC_NUM_EXT 3
`define VIC_HI_BITS 22

// ----------------------------------------------------------------------
// fixed source numbers
// ----------------------------------------------------------------------
`define VIC_EXT0_SRC 6'd22
`define VIC_EXT1_SRC 6'd33
`define VIC_EXT2_SRC 6'd40
`define VIC_GPIO_SRC 6'd53

// ----------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------
`define VIC_RAW_LO 8'h00
`define VIC_RAW_HI 8'h04
`define VIC_EN_LO 8'h08
`define VIC_EN_HI 8'h0C
`define VIC_SEL_LO 8'h10
`define VIC_SEL_HI 8'h14
`define VIC_POL_LO 8'h18
`define VIC_POL_HI 8'h1C
`define VIC_FPRI_LO 8'h20
`define VIC_FPRI_HI 8'h24
`define VIC_PRIMASK 8'h28
`define VIC_NORM_VEC 8'h2C
`define VIC_FAST_VEC 8'h30
`define VIC_GPIO_STAT 8'h34
`define VIC_GPIO_CLR 8'h38
`define VIC_GPIO_EN 8'h3C
`define VIC_GPIO_TYPE 8'h40
`define VIC_GPIO_POL 8'h44
`define VIC_GPIO_BOTH 8'h48
`define VIC_SLOT_BASE 8'h80

// ----------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------
`define VIC_PM_THR_MSB 5
`define VIC_PM_FHI_BIT 8
`define VIC_PM_FLO_BIT 9
`define VIC_VEC_VALID_BIT 8
`define VIC_SLOT_EN_BIT 8
`define VIC_THR_RESET 6'h21
`define VIC_RANK_NONE 6'h20

`endif

/* hw/vic_gpio_det.sv */
`timescale 1ns/100ps

module vic_gpio_det #(
  parameter int IDX = 0
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  vic_gpio_if.det g
);

  logic prev;
  logic rise;
  logic fall;
  logic evt;
  logic stat;
  logic level_hit;

  // ----------------------------------------------------------------------
  // edge and level detection
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      prev <= 1'b0;
    end else begin
      prev <= g.pin[IDX];
    end
  end

  assign rise = g.pin[IDX] & ~prev;
  assign fall = ~g.pin[IDX] & prev;
  // both-edge mode ignores polarity; single edge follows it
  assign evt = g.edge_mode[IDX] &
               (g.both[IDX] ? (rise | fall) :
                (g.pol[IDX] ? rise : fall));
  assign level_hit = g.pol[IDX] ? g.pin[IDX] : ~g.pin[IDX];

  // set wins over a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      stat <= 1'b0;
    end else if (evt) begin
      stat <= 1'b1;
    end else if (g.clr[IDX] || !g.edge_mode[IDX]) begin
      stat <= 1'b0;
    end
  end

  assign g.stat[IDX] = stat;
  assign g.hit[IDX] = g.en[IDX] &
                      (g.edge_mode[IDX] ? stat : level_hit);

endmodule : vic_gpio_det

/* hw/vic_gpio_if.sv */
`timescale 1ns/100ps

interface vic_gpio_if;
  vic_pkg::vic_gpiovec_t pin;
  vic_pkg::vic_gpiovec_t en;
  vic_pkg::vic_gpiovec_t edge_mode;
  vic_pkg::vic_gpiovec_t pol;
  vic_pkg::vic_gpiovec_t both;
  vic_pkg::vic_gpiovec_t clr;
  vic_pkg::vic_gpiovec_t stat;
  vic_pkg::vic_gpiovec_t hit;

  modport ctrl (
    output pin,
    output en,
    output edge_mode,
    output pol,
    output both,
    output clr,
    input stat,
    input hit
  );

  modport det (
    input pin,
    input en,
    input edge_mode,
    input pol,
    input both,
    input clr,
    output stat,
    output hit
  );
endinterface : vic_gpio_if

/* hw/vic_pkg.sv */
package vic_pkg;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef logic [53:0] vic_srcvec_t;
  typedef logic [5:0] vic_srcnum_t;
  typedef logic [18:0] vic_gpiovec_t;

  typedef struct packed {
    logic en;
    vic_srcnum_t src;
  } vic_slot_t;

endpackage : vic_pkg

/* hw/vic_top.sv */
// What this block does
// - up to 54 sources, each steered to the normal or the fast request.
// - 32 priority slots pick the vector of the best pending normal source.
// - fast sources carry one of two levels and the higher one is vectored.
// - internal sources are level inputs with selectable polarity.
// - pin sources trigger on high, low, rising, falling or both edges.
// - three off-chip lines are active-high level sources.
// - any of the 19 pins can be made an interrupt source.
// - a software priority mask gates both normal and fast sources.
// - off-chip lines 0, 1 and 2 land on source numbers 22, 33 and 40.
// is active.
//
// Our own choices: strobed register access and the address map.
`timescale 1ns/100ps
`include "vic_defines.svh"

module vic_top (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  input wire vic_pkg::vic_srcvec_t periph_irq_i,
  input wire vic_pkg::vic_gpiovec_t gpio_pin_i,
  input wire logic [2:0] ext_irq_i,
  output logic norm_irq_o,
  output logic fast_interrupt_request_o,
  output logic norm_vec_valid_o,
  output vic_pkg::vic_srcnum_t norm_vec_o,
  output logic fast_vec_valid_o,
  output vic_pkg::vic_srcnum_t fast_vec_o,
  output logic gpio_irq_o
);

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  vic_pkg::vic_srcvec_t enable;
  vic_pkg::vic_srcvec_t route_fast;
  vic_pkg::vic_srcvec_t active_low;
  vic_pkg::vic_srcvec_t fast_high;
  vic_pkg::vic_slot_t slot [`VIC_NUM_SLOT];
  logic [5:0] norm_thr;
  logic fast_hi_allow;
  logic fast_lo_allow;

  vic_pkg::vic_gpiovec_t gpio_en;
  vic_pkg::vic_gpiovec_t gpio_edge;
  vic_pkg::vic_gpiovec_t gpio_pol;
  vic_pkg::vic_gpiovec_t gpio_both;
  vic_pkg::vic_gpiovec_t gpio_sync1;
  vic_pkg::vic_gpiovec_t gpio_sync2;
  logic [2:0] ext_sync1;
  logic [2:0] ext_sync2;

  vic_pkg::vic_srcvec_t raw;
  vic_pkg::vic_srcvec_t norm_pass;
  vic_pkg::vic_srcvec_t fast_hi;
  vic_pkg::vic_srcvec_t fast_lo;
  logic [5:0] rank [`VIC_NUM_SRC];
  logic next_norm_valid;
  vic_pkg::vic_srcnum_t next_norm_vec;
  logic next_fast_valid;
  vic_pkg::vic_srcnum_t next_fast_vec;
  logic [31:0] next_rdata;
  logic gpio_any;
  logic slot_hit;
  logic [4:0] slot_idx;

  vic_gpio_if gif ();

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      gpio_sync1 <= 19'h00000;
      gpio_sync2 <= 19'h00000;
      ext_sync1 <= 3'h0;
      ext_sync2 <= 3'h0;
    end else begin
      gpio_sync1 <= gpio_pin_i;
      gpio_sync2 <= gpio_sync1;
      ext_sync1 <= ext_irq_i;
      ext_sync2 <= ext_sync1;
    end
  end

  // ----------------------------------------------------------------------
  // pin detectors
  // ----------------------------------------------------------------------
  assign gif.pin = gpio_sync2;
  assign gif.en = gpio_en;
  assign gif.edge_mode = gpio_edge;
  assign gif.pol = gpio_pol;
  assign gif.both = gpio_both;
  // clear pulse lasts exactly the write cycle
  assign gif.clr = (reg_wr_i && reg_addr_i == `VIC_GPIO_CLR) ?
                   reg_wdata_i[18:0] : 19'h00000;

  for (genvar p = 0; p < `VIC_NUM_GPIO; p++) begin : g_pin
    vic_gpio_det #(
      .IDX(p)
    ) u_det (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .g(gif.det)
    );
  end

  // all pins share one source slot, so software reads the pin status
  assign gpio_any = |gif.hit;

  // ----------------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------------
  assign slot_hit = reg_addr_i[7] && reg_addr_i[1:0] == 2'h0;
  assign slot_idx = reg_addr_i[6:2];

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      enable <= 54'h0;
      route_fast <= 54'h0;
      active_low <= 54'h0;
      fast_high <= 54'h0;
    end else if (reg_wr_i) begin
      unique case (reg_addr_i)
        `VIC_EN_LO: enable[31:0] <= reg_wdata_i;
        `VIC_EN_HI: enable[53:32] <= reg_wdata_i[21:0];
        `VIC_SEL_LO: route_fast[31:0] <= reg_wdata_i;
        `VIC_SEL_HI: route_fast[53:32] <= reg_wdata_i[21:0];
        `VIC_POL_LO: active_low[31:0] <= reg_wdata_i;
        `VIC_POL_HI: active_low[53:32] <= reg_wdata_i[21:0];
        `VIC_FPRI_LO: fast_high[31:0] <= reg_wdata_i;
        `VIC_FPRI_HI: fast_high[53:32] <= reg_wdata_i[21:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      norm_thr <= `VIC_THR_RESET;
      fast_hi_allow <= 1'b1;
      fast_lo_allow <= 1'b1;
    end else if (reg_wr_i && reg_addr_i == `VIC_PRIMASK) begin
      norm_thr <= reg_wdata_i[`VIC_PM_THR_MSB:0];
      fast_hi_allow <= reg_wdata_i[`VIC_PM_FHI_BIT];
      fast_lo_allow <= reg_wdata_i[`VIC_PM_FLO_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      gpio_en <= 19'h00000;
      gpio_edge <= 19'h00000;
      gpio_pol <= 19'h00000;
      gpio_both <= 19'h00000;
    end else if (reg_wr_i) begin
      unique case (reg_addr_i)
        `VIC_GPIO_EN: gpio_en <= reg_wdata_i[18:0];
        `VIC_GPIO_TYPE: gpio_edge <= reg_wdata_i[18:0];
        `VIC_GPIO_POL: gpio_pol <= reg_wdata_i[18:0];
        `VIC_GPIO_BOTH: gpio_both <= reg_wdata_i[18:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      for (int k = 0; k < `VIC_NUM_SLOT; k++) begin
        slot[k] <= '0;
      end
    end else if (reg_wr_i && slot_hit) begin
      slot[slot_idx].en <= reg_wdata_i[`VIC_SLOT_EN_BIT];
      slot[slot_idx].src <= reg_wdata_i[5:0];
    end
  end

  // ----------------------------------------------------------------------
  // source conditioning
  // ----------------------------------------------------------------------
  // polarity bits of the off-chip and pin slots have no effect
  always_comb begin
    raw = periph_irq_i ^ active_low;
    raw[`VIC_EXT0_SRC] = ext_sync2[0];
    raw[`VIC_EXT1_SRC] = ext_sync2[1];
    raw[`VIC_EXT2_SRC] = ext_sync2[2];
    raw[`VIC_GPIO_SRC] = gpio_any;
  end

  // ----------------------------------------------------------------------
  // priority ranking and masking
  // ----------------------------------------------------------------------
  // a source in several slots takes the best one; unslotted ones rank last
  always_comb begin
    for (int s = 0; s < `VIC_NUM_SRC; s++) begin
      rank[s] = `VIC_RANK_NONE;
    end
    for (int k = `VIC_NUM_SLOT - 1; k >= 0; k--) begin
      if (slot[k].en && slot[k].src < 6'(`VIC_NUM_SRC)) begin
        rank[slot[k].src] = 6'(k);
      end
    end
  end

  always_comb begin
    for (int s = 0; s < `VIC_NUM_SRC; s++) begin
      norm_pass[s] = raw[s] & enable[s] & ~route_fast[s] &
                     (rank[s] < norm_thr);
    end
  end

  assign fast_hi = raw & enable & route_fast & fast_high &
                   {54{fast_hi_allow}};
  assign fast_lo = raw & enable & route_fast & ~fast_high &
                   {54{fast_lo_allow}};

  // ----------------------------------------------------------------------
  // vector selection
  // ----------------------------------------------------------------------
  always_comb begin
    next_norm_valid = 1'b0;
    next_norm_vec = 6'h00;
    for (int k = `VIC_NUM_SLOT - 1; k >= 0; k--) begin
      if (slot[k].en && slot[k].src < 6'(`VIC_NUM_SRC) &&
          norm_pass[slot[k].src]) begin
        next_norm_valid = 1'b1;
        next_norm_vec = slot[k].src;
      end
    end
  end

  // high level first, then lowest source number within a level
  always_comb begin
    next_fast_valid = 1'b0;
    next_fast_vec = 6'h00;
    for (int s = `VIC_NUM_SRC - 1; s >= 0; s--) begin
      if (fast_lo[s]) begin
        next_fast_valid = 1'b1;
        next_fast_vec = 6'(s);
      end
    end
    for (int s = `VIC_NUM_SRC - 1; s >= 0; s--) begin
      if (fast_hi[s]) begin
        next_fast_valid = 1'b1;
        next_fast_vec = 6'(s);
      end
    end
  end

  // ----------------------------------------------------------------------
  // request outputs
  // ----------------------------------------------------------------------
  // registered to keep the core inputs glitch free, one cycle of latency
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      norm_irq_o <= 1'b0;
      fast_interrupt_request_o <= 1'b0;
      gpio_irq_o <= 1'b0;
    end else begin
      norm_irq_o <= |norm_pass;
      fast_interrupt_request_o <= |(fast_hi | fast_lo);
      gpio_irq_o <= gpio_any;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      norm_vec_valid_o <= 1'b0;
      norm_vec_o <= 6'h00;
      fast_vec_valid_o <= 1'b0;
      fast_vec_o <= 6'h00;
    end else begin
      norm_vec_valid_o <= next_norm_valid;
      norm_vec_o <= next_norm_vec;
      fast_vec_valid_o <= next_fast_valid;
      fast_vec_o <= next_fast_vec;
    end
  end

  // ----------------------------------------------------------------------
  // register reads
  // ----------------------------------------------------------------------
  always_comb begin
    next_rdata = 32'h00000000;
    if (slot_hit) begin
      next_rdata[`VIC_SLOT_EN_BIT] = slot[slot_idx].en;
      next_rdata[5:0] = slot[slot_idx].src;
    end else begin
      unique case (reg_addr_i)
        `VIC_RAW_LO: next_rdata = raw[31:0];
        `VIC_RAW_HI: next_rdata[21:0] = raw[53:32];
        `VIC_EN_LO: next_rdata = enable[31:0];
        `VIC_EN_HI: next_rdata[21:0] = enable[53:32];
        `VIC_SEL_LO: next_rdata = route_fast[31:0];
        `VIC_SEL_HI: next_rdata[21:0] = route_fast[53:32];
        `VIC_POL_LO: next_rdata = active_low[31:0];
        `VIC_POL_HI: next_rdata[21:0] = active_low[53:32];
        `VIC_FPRI_LO: next_rdata = fast_high[31:0];
        `VIC_FPRI_HI: next_rdata[21:0] = fast_high[53:32];
        `VIC_PRIMASK: begin
          next_rdata[`VIC_PM_THR_MSB:0] = norm_thr;
          next_rdata[`VIC_PM_FHI_BIT] = fast_hi_allow;
          next_rdata[`VIC_PM_FLO_BIT] = fast_lo_allow;
        end
        `VIC_NORM_VEC: begin
          next_rdata[5:0] = next_norm_vec;
          next_rdata[`VIC_VEC_VALID_BIT] = next_norm_valid;
        end
        `VIC_FAST_VEC: begin
          next_rdata[5:0] = next_fast_vec;
          next_rdata[`VIC_VEC_VALID_BIT] = next_fast_valid;
        end
        `VIC_GPIO_STAT: next_rdata[18:0] = gif.stat;
        `VIC_GPIO_EN: next_rdata[18:0] = gpio_en;
        `VIC_GPIO_TYPE: next_rdata[18:0] = gpio_edge;
        `VIC_GPIO_POL: next_rdata[18:0] = gpio_pol;
        `VIC_GPIO_BOTH: next_rdata[18:0] = gpio_both;
        default: next_rdata = 32'h00000000;
      endcase
    end
  end

  // data stands only in the cycle after the read strobe
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= 32'h00000000;
    end else begin
      reg_rdata_o <= reg_rd_i ? next_rdata : 32'h00000000;
    end
  end

endmodule : vic_top

/* sim/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  typedef struct {int s; logic d, sel, pol, en, ef;} vic_row_t;
  typedef struct {logic t, p, b, pre, nw, e;} vic_grow_t;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [31:0] reg_rdata_o, rd;
  vic_pkg::vic_srcvec_t periph_irq_i = '0, v;
  vic_pkg::vic_gpiovec_t gpio_pin_i = '0;
  logic [2:0] ext_irq_i = 3'h0;
  logic norm_irq_o, fast_o, nvv, fvv, gpio_irq_o;
  vic_pkg::vic_srcnum_t nvec, fvec, n_tk, f_tk;
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;
  int ext_src[3] = '{22, 33, 40};
  vic_row_t rows[8] = '{'{3,1,0,0,1,0}, '{3,0,0,1,1,0}, '{5,1,1,0,0,1},
    '{5,1,1,1,0,0}, '{45,1,0,0,1,0}, '{52,1,1,0,0,1}, '{0,0,0,0,0,0},
    '{31,1,0,0,1,0}};
  vic_grow_t grows[7] = '{'{0,1,0,0,1,1}, '{0,0,0,1,0,1}, '{1,1,0,0,1,1},
    '{1,0,0,1,0,1}, '{1,0,1,1,0,1}, '{1,1,1,0,1,1}, '{1,1,0,1,0,0}};
  always #2 clk_i = ~clk_i;
  vic_top dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .periph_irq_i(periph_irq_i), .gpio_pin_i(gpio_pin_i),
    .ext_irq_i(ext_irq_i), .norm_irq_o(norm_irq_o),
    .fast_interrupt_request_o(fast_o), .norm_vec_valid_o(nvv),
    .norm_vec_o(nvec), .fast_vec_valid_o(fvv), .fast_vec_o(fvec),
    .gpio_irq_o(gpio_irq_o));
  vic_core_model core_u (.clk_i(clk_i), .norm_irq_i(norm_irq_o),
    .fast_irq_i(fast_o), .norm_vec_valid_i(nvv), .norm_vec_i(nvec),
    .fast_vec_i(fvec), .norm_taken_o(n_tk), .fast_taken_o(f_tk));
  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task automatic chk_bit(string nm, logic e, logic g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit
  task automatic chk_word(string nm, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_word
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  task automatic rdreg(logic [7:0] a);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 rd = reg_rdata_o;
  endtask : rdreg
  task automatic wr54(logic [7:0] a, vic_pkg::vic_srcvec_t d);
    wr(a, d[31:0]);
    wr(a + 8'h04, {10'h0, d[53:32]});
  endtask : wr54
  task automatic wait_n(int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : wait_n
  task automatic reqs(logic n, logic f, string nm);
    chk_bit({nm, " normal"}, n, norm_irq_o);
    chk_bit({nm, " fast"}, f, fast_o);
  endtask : reqs
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : tally_and_finish
  // a hang costs a mismatch; the whole run needs under six hundred cycles
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  // ------------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rdreg(8'h28);
    chk_word("mask reset", 32'h321, rd);
    rdreg(8'h08);
    chk_word("enable reset", 32'h0, rd);
    rdreg(8'h4C);
    chk_word("unmapped", 32'h0, rd);
    rdreg(8'h38);
    chk_word("clear reg", 32'h0, rd);
    foreach (rows[i]) begin
      v = '0;
      v[rows[i].s] = 1'b1;
      wr54(8'h08, v);
      wr54(8'h10, rows[i].sel ? v : '0);
      wr54(8'h18, rows[i].pol ? v : '0);
      wr(8'h80, 32'h100 | rows[i].s);
      @(posedge clk_i) periph_irq_i <= rows[i].d ? v : '0;
      wait_n(3);
      reqs(rows[i].en, rows[i].ef, "row");
      chk_bit("nvalid", rows[i].en, nvv);
      chk_bit("fvalid", rows[i].ef, fvv);
      if (rows[i].en) chk_word("nvec", rows[i].s, nvec);
      if (rows[i].ef) chk_word("fvec", rows[i].s, fvec);
      wr54(8'h18, '0);
      @(posedge clk_i) periph_irq_i <= '0;
    end
    $display("test rows done");
    v = '0;
    v[3] = 1'b1;
    v[7] = 1'b1;
    wr54(8'h08, v);
    wr54(8'h10, '0);
    wr(8'h80, 32'h107);
    wr(8'h84, 32'h103);
    @(posedge clk_i) periph_irq_i <= v;
    wait_n(5);
    chk_word("prio vec", 32'h7, nvec);
    chk_word("core nvec", 32'h7, n_tk);
    rdreg(8'h2C);
    chk_word("nvec reg", 32'h107, rd);
    wr(8'h28, 32'h301);
    @(posedge clk_i) periph_irq_i <= 54'h8;
    wait_n(3);
    reqs(1'b0, 1'b0, "thr 1");
    wr(8'h28, 32'h302);
    wait_n(3);
    reqs(1'b1, 1'b0, "thr 2");
    chk_word("thr vec", 32'h3, nvec);
    wr(8'h28, 32'h321);
    $display("test priority done");
    v = '0;
    v[4] = 1'b1;
    v[9] = 1'b1;
    wr(8'h80, 32'h0);
    wr(8'h84, 32'h0);
    wr54(8'h08, v);
    wr54(8'h10, v);
    wr(8'h20, 32'h200);
    @(posedge clk_i) periph_irq_i <= v;
    wait_n(5);
    reqs(1'b0, 1'b1, "fast");
    chk_word("fast hi", 32'h9, fvec);
    chk_word("core fvec", 32'h9, f_tk);
    rdreg(8'h30);
    chk_word("fvec reg", 32'h109, rd);
    wr(8'h28, 32'h221);
    wait_n(3);
    chk_word("fast lo", 32'h4, fvec);
    wr(8'h28, 32'h021);
    wait_n(3);
    reqs(1'b0, 1'b0, "fast off");
    wr(8'h28, 32'h000);
    wait_n(3);
    reqs(1'b0, 1'b0, "mask all");
    wr(8'h28, 32'h321);
    wr54(8'h10, '0);
    @(posedge clk_i) periph_irq_i <= '0;
    $display("test fast done");
    for (int i = 0; i < 3; i++) begin
      v = '0;
      v[ext_src[i]] = 1'b1;
      wr54(8'h08, v);
      @(posedge clk_i) periph_irq_i <= v;
      wait_n(3);
      reqs(1'b0, 1'b0, "port bit");
      @(posedge clk_i) periph_irq_i <= '0;
      ext_irq_i <= 3'h1 << i;
      wait_n(5);
      reqs(1'b1, 1'b0, "ext");
      rdreg(8'h00);
      chk_word("raw lo", v[31:0], rd);
      rdreg(8'h04);
      chk_word("raw hi", {10'h0, v[53:32]}, rd);
      @(posedge clk_i) ext_irq_i <= 3'h0;
      wait_n(5);
      reqs(1'b0, 1'b0, "ext off");
    end
    $display("test ext done");
    v = '0;
    v[53] = 1'b1;
    wr54(8'h08, v);
    wr(8'h3C, 32'h40000);
    foreach (grows[i]) begin
      wr(8'h40, {13'h0, grows[i].t, 18'h0});
      wr(8'h44, {13'h0, grows[i].p, 18'h0});
      wr(8'h48, {13'h0, grows[i].b, 18'h0});
      @(posedge clk_i) gpio_pin_i[18] <= grows[i].pre;
      wait_n(6);
      wr(8'h38, 32'h7FFFF);
      @(posedge clk_i) gpio_pin_i[18] <= grows[i].nw;
      wait_n(6);
      chk_bit("pin irq", grows[i].e, gpio_irq_o);
      reqs(grows[i].e, 1'b0, "pin");
      wr(8'h38, 32'h7FFFF);
      wait_n(4);
      chk_bit("pin clr", grows[i].e & ~grows[i].t, gpio_irq_o);
    end
    $display("test pins done");
    @(posedge clk_i) reset_n_i <= 1'b0;
    wait_n(3);
    @(posedge clk_i) reset_n_i <= 1'b1;
    rdreg(8'h3C);
    chk_word("pin en reset", 32'h0, rd);
    rdreg(8'h28);
    chk_word("mask again", 32'h321, rd);
    $display("test reset done");
    tally_and_finish();
  end
endmodule : tb_top

/* sim/vic_core_model.sv */
`timescale 1ns/100ps
// the core enters its handler one cycle after it sees a request rise
// and reads the vector only then, so a late vector is caught
module vic_core_model (
  input wire logic clk_i,
  input wire logic norm_irq_i,
  input wire logic fast_irq_i,
  input wire logic norm_vec_valid_i,
  input wire vic_pkg::vic_srcnum_t norm_vec_i,
  input wire vic_pkg::vic_srcnum_t fast_vec_i,
  output vic_pkg::vic_srcnum_t norm_taken_o,
  output vic_pkg::vic_srcnum_t fast_taken_o
);
  logic [1:0] n_d = 2'h0;
  logic [1:0] f_d = 2'h0;
  initial norm_taken_o = 6'h3F;
  initial fast_taken_o = 6'h3F;
  always @(posedge clk_i) begin
    n_d <= {n_d[0], norm_irq_i};
    f_d <= {f_d[0], fast_irq_i};
    if (n_d == 2'h1 && norm_vec_valid_i) norm_taken_o <= norm_vec_i;
    if (f_d == 2'h1) fast_taken_o <= fast_vec_i;
  end
endmodule : vic_core_model

/* sim/vic_props.sv */
`timescale 1ns/100ps
module vic_props (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire vic_pkg::vic_srcvec_t periph_irq_i,
  input wire logic [2:0] ext_irq_i,
  input wire logic norm_irq_o,
  input wire logic fast_interrupt_request_o,
  input wire logic norm_vec_valid_o,
  input wire vic_pkg::vic_srcnum_t norm_vec_o,
  input wire logic fast_vec_valid_o,
  input wire vic_pkg::vic_srcnum_t fast_vec_o,
  input wire logic gpio_irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  // bits 22,33,40,53 come from off-chip lines and pins, not this port
  localparam vic_pkg::vic_srcvec_t QMASK =
    ~(54'h1 << 22 | 54'h1 << 33 | 54'h1 << 40 | 54'h1 << 53);
  logic [2:0] quiet_cnt;
  logic [2:0] pol_nz;
  logic blk;
  logic [1:0] blk_cnt;
  // active-low polarity or an enabled pin can make a source live at once;
  // a pin hit shows on gpio_irq_o no later than on the request itself
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      pol_nz <= 3'h0;
    end else if (reg_wr_i && reg_addr_i == 8'h18) begin
      pol_nz[0] <= |reg_wdata_i;
    end else if (reg_wr_i && reg_addr_i == 8'h1C) begin
      pol_nz[1] <= |reg_wdata_i[21:0];
    end else if (reg_wr_i && reg_addr_i == 8'h3C) begin
      pol_nz[2] <= |reg_wdata_i[18:0];
    end
  end
  always_ff @(posedge clk_i) begin
    if (!reset_n_i || pol_nz != 3'h0 || ext_irq_i != 3'h0 || gpio_irq_o ||
        (periph_irq_i & QMASK) != '0) begin
      quiet_cnt <= 3'h0;
    end else if (quiet_cnt != 3'h7) begin
      quiet_cnt <= quiet_cnt + 3'h1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      blk <= 1'b0;
      blk_cnt <= 2'h0;
    end else if (reg_wr_i && reg_addr_i == 8'h28) begin
      blk <= reg_wdata_i[9:8] == 2'h0 && reg_wdata_i[5:0] == 6'h0;
      blk_cnt <= 2'h0;
    end else if (blk && blk_cnt != 2'h3) begin
      blk_cnt <= blk_cnt + 2'h1;
    end
  end
  // ------------------------------------------------------------------
  // properties
  // ------------------------------------------------------------------
  property p_first_after;
    $rose(reset_n_i) |-> !norm_irq_o && !fast_interrupt_request_o;
  endproperty
  a_first_after: assert property (p_first_after)
    else $error("request high right after reset");
  property p_quiet;
    quiet_cnt >= 3'h5 |-> !norm_irq_o && !fast_interrupt_request_o;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("request with no active source");
  property p_mask_all;
    blk && blk_cnt >= 2'h2 |-> !norm_irq_o && !fast_interrupt_request_o;
  endproperty
  a_mask_all: assert property (p_mask_all)
    else $error("request while everything is masked");
  property p_fast_pair;
    fast_interrupt_request_o == fast_vec_valid_o;
  endproperty
  a_fast_pair: assert property (p_fast_pair)
    else $error("fast request and fast vector disagree");
  property p_fast_range;
    fast_vec_valid_o |-> fast_vec_o < 6'h36;
  endproperty
  a_fast_range: assert property (p_fast_range)
    else $error("fast vector out of range");
  property p_norm_vec;
    norm_vec_valid_o |-> norm_irq_o && norm_vec_o < 6'h36;
  endproperty
  a_norm_vec: assert property (p_norm_vec)
    else $error("normal vector without request");
  property p_rd_idle;
    !reg_rd_i |=> reg_rdata_o == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside read slot");
  property p_rd_hole;
    reg_rd_i && reg_addr_i == 8'h38 |=> reg_rdata_o == 32'h0;
  endproperty
  a_rd_hole: assert property (p_rd_hole)
    else $error("write-only register read nonzero");
endmodule : vic_props

bind vic_top vic_props chk_u (.clk_i(clk_i), .reset_n_i(reset_n_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .periph_irq_i(periph_irq_i), .ext_irq_i(ext_irq_i),
  .norm_irq_o(norm_irq_o),
  .fast_interrupt_request_o(fast_interrupt_request_o),
  .norm_vec_valid_o(norm_vec_valid_o), .norm_vec_o(norm_vec_o),
  .fast_vec_valid_o(fast_vec_valid_o), .fast_vec_o(fast_vec_o),
  .gpio_irq_o(gpio_irq_o));
